// [tdcr_top.sv]
// Readout, reset, interval timer and flag logic of a two-channel converter.
// Assumes synchronous pins and a host that never reads an empty FIFO.
//
// Notes on behaviour
// - Bit 22 edge type, bits 21..0 time.
// - Address 8 reads FIFO one, 9 two.
// - Power-up reset pin low resets everything.
// - Software master reset keeps configuration and the read data word.
// - Non-quiet: trigger pin high may master reset.
// - Quiet: output enable low may master reset.
// - Partial reset keeps configuration and FIFO contents.
// - Partial reset from trigger or output enable.
// - Inputs blocked 40 ns after full reset.
// - Inputs blocked 75 ns after partial reset.
// - Timer period in reference clocks, max 8191.
// - Timer launched by start, stop or either.
// - Timer end sets interrupt when enabled.
// - Interrupt is OR of unmasked events.
// - Error is OR of unmasked events 0..10.
// - Test select routes test inputs instead.
// - Trim 0..3 widens pulse-pair resolution.
`timescale 1ns/1ps
module tdcr_top
    import tdcr_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic power_up_reset_low_pin,      // Whole-device reset, low active.
    // Configuration bits.
    input wire logic quiet_mode,
    input wire logic master_reset_on_trigger_pin,
    input wire logic master_reset_on_output_enable,
    input wire logic partial_reset_on_trigger_pin,
    input wire logic partial_reset_on_output_enable,
    input wire logic timer_launch_on_start,
    input wire logic timer_launch_on_stop,
    input wire logic [TDCR_TIMER_W-1:0] timer_period,
    input wire logic timer_interrupt_enable,
    input wire logic [TDCR_IRQ_W-1:0] irq_mask,   // 1 unmasks an event.
    input wire logic [TDCR_ERR_W-1:0] err_mask,
    input wire logic test_select,
    input wire logic [1:0] extra_delay_speed,
    // Software commands, one-cycle pulses.
    input wire logic sw_master_reset,
    input wire logic sw_partial_reset,
    // Pins.
    input wire logic trigger_pin,
    input wire logic output_enable_n,
    input wire logic ref_tick,                    // One-cycle reference clock enable.
    input wire logic start_in,
    input wire logic stop_input_one,
    input wire logic stop_input_two,
    input wire logic [2:0] test_inputs,           // Test start, stop one, stop two.
    input wire logic [TDCR_HIT_N-1:0] hit_fifo_full,
    input wire logic hit_all_empty,
    input wire logic pll_unlocked,
    // Results from the measuring core.
    input wire logic [TDCR_TIME_W-1:0] res_time,
    input wire logic res_rising,
    input wire logic res_chan,                    // 0 stop one, 1 stop two.
    input wire logic res_valid,
    output logic res_ready,
    // Host read port.
    input wire logic [3:0] rd_addr,
    input wire logic rd_strobe,
    output logic [TDCR_WORD_W-1:0] rd_data,
    output logic fifo_empty_flag_one,
    output logic fifo_empty_flag_two,
    // Status.
    output logic inputs_open,
    output logic start_gated,
    output logic stop_one_gated,
    output logic stop_two_gated,
    output logic [13:0] pair_res_ps,
    output logic irq_out_flag,
    output logic error_out_flag
);
    // ==========================================================
    // Reset sources.
    logic pur, trig_hi, oen_lo, mreset, preset;
    logic [TDCR_WORD_W-1:0] word;
    logic [1:0] fv, fr, inr;
    logic [TDCR_WORD_W-1:0] fd [2];
    always_comb begin
        pur = !resetn || !power_up_reset_low_pin;
        trig_hi = !quiet_mode && trigger_pin;
        oen_lo = quiet_mode && !output_enable_n;
        mreset = sw_master_reset
            || (trig_hi && master_reset_on_trigger_pin)
            || (oen_lo && master_reset_on_output_enable);
        preset = sw_partial_reset
            || (trig_hi && partial_reset_on_trigger_pin)
            || (oen_lo && partial_reset_on_output_enable);
    end
    // ==========================================================
    // Result word packing and the two FIFOs; master reset flushes them,
    // partial reset leaves them alone.
    assign word = {res_rising, res_time};
    assign res_ready = res_chan ? inr[1] : inr[0];
    for (genvar g = 0; g < 2; g++) begin : g_fifo
        tdcr_fifo #(.WIDTH(TDCR_WORD_W), .DEPTH(DEPTH)) u_fifo (
            .clock(clock),
            .resetn(resetn && power_up_reset_low_pin),
            .clear(mreset),
            .in_data(word),
            .in_valid(res_valid && (res_chan == 1'(g)) && inputs_open),
            .in_ready(inr[g]),
            .out_data(fd[g]),
            .out_valid(fv[g]),
            .out_ready(fr[g])
        );
    end
    assign fr[0] = rd_strobe && rd_addr == TDCR_ADDR_FIFO1;
    assign fr[1] = rd_strobe && rd_addr == TDCR_ADDR_FIFO2;
    assign fifo_empty_flag_one = !fv[0];
    assign fifo_empty_flag_two = !fv[1];
    // ==========================================================
    // Read data register; an empty read leaves the word unchanged.
    logic [TDCR_WORD_W-1:0] rd_data_r, rd_data_nxt;
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (fr[0] && fv[0]) begin
            rd_data_nxt = fd[0];
        end else if (fr[1] && fv[1]) begin
            rd_data_nxt = fd[1];
        end
    end
    assign rd_data = rd_data_r;
    // ==========================================================
    // Input hold-off counter after resets. A longer pending count is
    // never shortened by a later master reset, only by the power-up reset.
    localparam int HW = 8;
    logic [HW-1:0] hold_r, hold_nxt;
    always_comb begin
        hold_nxt = (hold_r != '0) ? HW'(hold_r - 1'b1) : hold_r;
        if (preset) begin
            hold_nxt = HW'(TDCR_HOLD_PART_CYC);
        end else if (mreset && hold_nxt < HW'(TDCR_HOLD_FULL_CYC)) begin
            hold_nxt = HW'(TDCR_HOLD_FULL_CYC);
        end
    end
    assign inputs_open = (hold_r == '0);
    // Test inputs replace the normal ones when selected.
    always_comb begin
        start_gated = inputs_open && (test_select ? test_inputs[0] : start_in);
        stop_one_gated = inputs_open && (test_select ? test_inputs[1] : stop_input_one);
        stop_two_gated = inputs_open && (test_select ? test_inputs[2] : stop_input_two);
    end
    // Delay trim reported as resulting pulse-pair resolution.
    assign pair_res_ps = 14'(TDCR_TRIM_PS_BASE) + 14'(extra_delay_speed) * 14'(TDCR_TRIM_PS_STEP);
    // ==========================================================
    // Interval timer, counted in reference clock ticks.
    logic [TDCR_TIMER_W-1:0] tmr_r, tmr_nxt;
    logic run_r, run_nxt, tend_r, tend_nxt, launch;
    always_comb begin
        launch = (timer_launch_on_start && start_gated)
            || (timer_launch_on_stop && (stop_one_gated || stop_two_gated));
        tmr_nxt = tmr_r;
        run_nxt = run_r;
        tend_nxt = tend_r;
        if (launch && !run_r) begin
            tmr_nxt = timer_period;
            run_nxt = (timer_period != '0);
            tend_nxt = 1'b0;
        end else if (run_r && ref_tick) begin
            tmr_nxt = TDCR_TIMER_W'(tmr_r - 1'b1);
            if (tmr_r == TDCR_TIMER_W'(1)) begin
                run_nxt = 1'b0;
                tend_nxt = 1'b1;
            end
        end
        if (mreset || preset) begin
            run_nxt = 1'b0;
            tend_nxt = 1'b0;
        end
    end
    // ==========================================================
    // Flag aggregation; event vector bits 0..7 hit FIFOs, 8..9 interface
    // FIFOs, 10 PLL, 11 all empty, 12 timer end.
    logic [TDCR_IRQ_W-1:0] ev;
    always_comb begin
        ev = {tend_r && timer_interrupt_enable, hit_all_empty, pll_unlocked,
              !inr[1], !inr[0], hit_fifo_full};
        irq_out_flag = |(ev & irq_mask);
        error_out_flag = |(ev[TDCR_ERR_W-1:0] & err_mask);
    end
    // ==========================================================
    // Registers; the power-up pin also resets the state, loading the full hold-off count.
    always_ff @(posedge clock) begin
        if (pur) begin
            hold_r <= HW'(TDCR_HOLD_FULL_CYC);
            tmr_r <= '0;
            run_r <= 1'b0;
            tend_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            hold_r <= hold_nxt;
            tmr_r <= tmr_nxt;
            run_r <= run_nxt;
            tend_r <= tend_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end
    // ==========================================================
    // Checks.
    property hold_part_p;
        @(posedge clock) disable iff (pur)
        preset |=> !inputs_open [*8] ##1 (!inputs_open || !$past(inputs_open, 1)) ;
    endproperty
    hold_part_a: assert property (hold_part_p) else $error("partial hold-off short");
    hold_full_a: assert property (@(posedge clock) disable iff (pur)
        (mreset && !preset) |=> !inputs_open [*8]) else $error("full hold-off short");
    edge_bit_a: assert property (@(posedge clock) disable iff (pur)
        (fr[0] && fv[0]) |=> rd_data[TDCR_EDGE_BIT] == $past(fd[0][TDCR_EDGE_BIT]))
        else $error("edge bit wrong");
    fifo_two_a: assert property (@(posedge clock) disable iff (pur)
        (fr[1] && fv[1] && !fr[0]) |=> rd_data == $past(fd[1])) else $error("fifo two read wrong");
    mreset_trig_a: assert property (@(posedge clock) disable iff (pur)
        (!quiet_mode && trigger_pin && master_reset_on_trigger_pin) |=> !fv[0] && !fv[1])
        else $error("trigger master reset missed");
    mreset_oen_a: assert property (@(posedge clock) disable iff (pur)
        (quiet_mode && !output_enable_n && master_reset_on_output_enable) |=> !fv[0])
        else $error("oen master reset missed");
    timer_end_a: assert property (@(posedge clock) disable iff (pur)
        (run_r && ref_tick && tmr_r == 13'h0001 && !mreset && !preset) |=> tend_r)
        else $error("timer end missed");
    irq_or_a: assert property (@(posedge clock) disable iff (pur)
        (irq_mask[10] && pll_unlocked) |-> irq_out_flag) else $error("irq not raised");
    err_or_a: assert property (@(posedge clock) disable iff (pur)
        (err_mask == '0) |-> !error_out_flag) else $error("error flag unmasked");
    test_mux_a: assert property (@(posedge clock) disable iff (pur)
        (test_select && inputs_open) |-> start_gated == test_inputs[0]) else $error("test mux");
endmodule : tdcr_top

// [tdcr_pkg.sv]
// Package for the converter readout, reset, timer and flag logic.
// Assumes a single 250 MHz clock and plain configuration ports.
package tdcr_pkg;
    // ==========================================================
    // Result word layout.
    localparam int TDCR_EDGE_BIT = 22;       // Edge type bit, 1 is rising.
    localparam int TDCR_TIME_W = 22;         // Time field, bits 21..0.
    localparam int TDCR_WORD_W = 23;         // Whole result word.
    // ==========================================================
    // Read addresses of the two interface FIFOs.
    localparam logic [3:0] TDCR_ADDR_FIFO1 = 4'h8;
    localparam logic [3:0] TDCR_ADDR_FIFO2 = 4'h9;
    // ==========================================================
    // Timing figures and derived cycle counts.
    localparam int TDCR_CLK_PS = 4000;       // Clock period in ps.
    localparam int TDCR_HOLD_FULL_NS = 40;   // Input hold-off after full reset.
    localparam int TDCR_HOLD_PART_NS = 75;   // Input hold-off after partial reset.
    localparam int TDCR_HOLD_FULL_CYC = (TDCR_HOLD_FULL_NS * 1000 + TDCR_CLK_PS - 1) / TDCR_CLK_PS;
    localparam int TDCR_HOLD_PART_CYC = (TDCR_HOLD_PART_NS * 1000 + TDCR_CLK_PS - 1) / TDCR_CLK_PS;
    localparam int TDCR_TIMER_W = 13;        // Timer count, maximum 8191.
    localparam int TDCR_TRIM_PS_BASE = 5500; // Pulse-pair resolution at trim 0.
    localparam int TDCR_TRIM_PS_STEP = 1000; // Added per trim step.
    // ==========================================================
    // Flag mask widths.
    localparam int TDCR_IRQ_W = 13;          // Interrupt mask bits 13..25.
    localparam int TDCR_ERR_W = 11;          // Error mask bits 16..26.
    localparam int TDCR_HIT_N = 8;           // Number of hit FIFOs.
endpackage : tdcr_pkg

// [tdcr_fifo.sv]
// Parameterised synchronous FIFO for result words.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tdcr_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear,                  // Flush contents.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];           // Storage array.
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;             // Fill level.
    logic wr, rd;
    // ==========================================================
    // Pointer and level update; full and empty come from the level.
    // Full when the level reaches the depth; the level is one bit wider than a pointer.
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    always_comb begin
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_nxt = wr ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = rd ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        if (clear) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // Memory writes carry no reset; contents are don't-care when empty.
    always_ff @(posedge clock) begin
        if (wr && !clear) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule : tdcr_fifo

// [tdcr_host_model.sv]
// Host-side read model for the two result FIFOs.
// Assumes the bench moves req by non-blocking assignment on the falling edge.
`timescale 1ns/1ps
module tdcr_host_model (
    input wire logic clock,
    input wire logic req,
    input wire logic sel_two,
    input wire logic empty_one,
    input wire logic empty_two,
    output logic [3:0] rd_addr,
    output logic rd_strobe
);
    // ============================================================
    // Read requests
    // Idle reads park on an address the block ignores, never on a FIFO.
    // Requests move half a cycle away from the sampling edge.
    // A read is only issued while the chosen FIFO holds data.
    always @(negedge clock) begin
        rd_strobe <= req && !(sel_two ? empty_two : empty_one);
        rd_addr <= !req ? 4'h0 : (sel_two ? 4'h9 : 4'h8);
    end
endmodule : tdcr_host_model

// [tdc_readout_reset_timer_flags_bench.sv]
// Self-checking bench for the readout, reset, timer and flag block.
// Assumes the host model above and a 250 MHz clock made here.
`timescale 1ns/1ps
module tdc_readout_reset_timer_flags_bench import tdcr_pkg::*;;
    // ============================================================
    // Stimulus and observed signals
    logic clock, resetn, pur_n, quiet, m_trig, m_oen, p_trig, p_oen, l_start, l_stop;
    logic t_ien, test_sel, sw_m, sw_p, trig, oen_n, tick, start_in, stop1, stop2;
    logic all_empty, pll, rrise, rchan, rvalid, req, sel2, res_ready, rd_strobe;
    logic ef1, ef2, in_open, sg, s1g, s2g, irq, err;
    logic [12:0] period, irqm;
    logic [10:0] errm;
    logic [1:0] speed;
    logic [2:0] tin;
    logic [7:0] hitf;
    logic [21:0] rtime;
    logic [3:0] rd_addr;
    logic [22:0] rd_data;
    logic [13:0] pres;
    logic [8:0] cfg [8] = '{9'h008, 9'h004, 9'h082, 9'h022, 9'h140, 9'h110, 9'h001, 9'h182};
    int fail_count = 0;
    int tests_run = 0;

    tdcr_top #(.DEPTH(8)) i_tdcr_top (.clock(clock), .resetn(resetn),
        .power_up_reset_low_pin(pur_n), .quiet_mode(quiet), .master_reset_on_trigger_pin(m_trig),
        .master_reset_on_output_enable(m_oen), .partial_reset_on_trigger_pin(p_trig),
        .partial_reset_on_output_enable(p_oen), .timer_launch_on_start(l_start),
        .timer_launch_on_stop(l_stop), .timer_period(period), .timer_interrupt_enable(t_ien),
        .irq_mask(irqm), .err_mask(errm), .test_select(test_sel), .extra_delay_speed(speed),
        .sw_master_reset(sw_m), .sw_partial_reset(sw_p), .trigger_pin(trig),
        .output_enable_n(oen_n), .ref_tick(tick), .start_in(start_in), .stop_input_one(stop1),
        .stop_input_two(stop2), .test_inputs(tin), .hit_fifo_full(hitf),
        .hit_all_empty(all_empty), .pll_unlocked(pll), .res_time(rtime), .res_rising(rrise),
        .res_chan(rchan), .res_valid(rvalid), .res_ready(res_ready), .rd_addr(rd_addr),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .fifo_empty_flag_one(ef1),
        .fifo_empty_flag_two(ef2), .inputs_open(in_open), .start_gated(sg),
        .stop_one_gated(s1g), .stop_two_gated(s2g), .pair_res_ps(pres), .irq_out_flag(irq),
        .error_out_flag(err));
    tdcr_host_model i_tdcr_host_model (.clock(clock), .req(req), .sel_two(sel2),
        .empty_one(ef1), .empty_two(ef2), .rd_addr(rd_addr), .rd_strobe(rd_strobe));

    // ============================================================
    // Shared tasks
    // Case inequality lets an unknown value count as a mismatch.
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // Holds the result until the edge that takes it, then withdraws it.
    task automatic push(logic ch, logic rise, logic [21:0] t);
        int n = 0;
        @(negedge clock);
        {rchan, rrise, rtime, rvalid} = {ch, rise, t, 1'b1};
        #1;
        while (!(res_ready === 1'b1 && in_open === 1'b1) && n < 40) begin
            @(negedge clock);
            n++;
        end
        check("push taken", 1, n < 40);
        @(negedge clock);
        rvalid = 1'b0;
    endtask : push
    // One read through the host model; the word is settled a cycle later.
    task automatic read(logic two, logic [22:0] exp);
        @(negedge clock);
        sel2 = two;
        req <= 1'b1;
        @(negedge clock);
        req <= 1'b0;
        @(negedge clock);
        check("read word", exp, rd_data);
    endtask : read
    // Measures from the taking edge, half a cycle back, until inputs reopen.
    task automatic hold(int ns);
        realtime t0 = $realtime - 2.0;
        int n = 0;
        while (in_open !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        check("hold span", 1, ($realtime - t0 >= ns) && ($realtime - t0 <= ns + 12));
    endtask : hold

    // ============================================================
    // Clock, watchdog and test sequence
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // The tests take a few hundred cycles; this span is 25000 cycles.
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        // Stops stay low while configuring, and a reset precedes any measurement.
        {resetn, pur_n, quiet, m_trig, m_oen, p_trig, p_oen, l_start, l_stop} = 9'h080;
        {t_ien, test_sel, sw_m, sw_p, trig, oen_n, tick, start_in, stop1, stop2} = 10'h018;
        {all_empty, pll, rrise, rchan, rvalid, req, sel2} = 7'h00;
        {period, irqm, errm, speed, tin, hitf, rtime} = '0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        hold(TDCR_HOLD_FULL_NS);
        check("empty after reset", 1, ef1 & ef2);
        $display("test reset release done");
        // Every reset source, plus a trigger in the wrong mode that must do nothing.
        for (int s = 0; s < 8; s++) begin
            push(1'b0, s[0], 22'h3F_FF00 + 22'(s));
            {quiet, m_trig, m_oen, p_trig, p_oen} = cfg[s][8:4];
            @(negedge clock);
            {sw_m, sw_p, trig, pur_n} = {cfg[s][3:1], !cfg[s][0]};
            oen_n = !(cfg[s][6] | cfg[s][4]);
            @(negedge clock);
            {sw_m, sw_p, trig, oen_n, pur_n} = 5'h03;
            if (s == 7) check("no reset", 1, in_open);
            else hold((s < 6 && s[0]) ? TDCR_HOLD_PART_NS : TDCR_HOLD_FULL_NS);
            check("flush", (s < 6 && !s[0]) || s == 6, ef1);
            if (ef1 === 1'b0) read(1'b0, {s[0], 22'h3F_FF00 + 22'(s)});
            {quiet, m_trig, m_oen, p_trig, p_oen} = '0;
            $display("test reset source %0d done", s);
        end
        // Fill the second FIFO until it refuses, then drain it in order.
        for (int i = 0; i < 8; i++) push(1'b1, i[0], 22'h00_0100 * 22'(i + 1));
        rchan = 1'b1;
        {irqm, errm} = {13'h0300, 11'h300};
        #1;
        check("fifo full refuses", 0, res_ready);
        check("iface full irq", 1, irq);
        check("iface full err", 1, err);
        for (int i = 0; i < 8; i++) read(1'b1, {i[0], 22'h00_0100 * 22'(i + 1)});
        check("drained", 1, ef2);
        check("irq after drain", 0, irq);
        $display("test fifo fill done");
        // Each directly driven event through each mask, alone and masked off.
        for (int i = 0; i < 12; i++) begin
            if (i == 8 || i == 9) continue;
            @(negedge clock);
            {all_empty, pll, hitf} = 10'(13'h0001 << i >> (i > 9 ? 2 : 0));
            {irqm, errm} = {13'h0001 << i, 11'(13'h0001 << i)};
            #1;
            check("irq unmasked", 1, irq);
            check("err unmasked", i < 11, err);
            {irqm, errm} = ~{13'h0001 << i, 11'(13'h0001 << i)};
            #1;
            check("irq masked", 0, irq);
            check("err masked", 0, err);
        end
        {all_empty, pll, hitf, errm} = '0;
        $display("test flags done");
        // Timer launched by start, then by stop, ending in the interrupt flag.
        for (int m = 0; m < 2; m++) begin
            {period, t_ien, irqm, l_start, l_stop} = {13'h0003, 1'b1, 13'h1000, !m[0], m[0]};
            @(negedge clock);
            {start_in, stop1} = {!m[0], m[0]};
            @(negedge clock);
            {start_in, stop1} = 2'b00;
            begin
                int n = 0;
                while (irq !== 1'b1 && n < 20) begin
                    @(negedge clock);
                    n++;
                end
                check("timer span", 1, n >= 2 && n <= 6);
            end
            sw_m = 1'b1;
            @(negedge clock);
            sw_m = 1'b0;
            hold(TDCR_HOLD_FULL_NS);
            check("timer cleared", 0, irq);
        end
        $display("test timer done");
        // Trim settings and the test-input multiplexer.
        for (int t = 0; t < 4; t++) begin
            @(negedge clock);
            speed = 2'(t);
            #1;
            check("pair resolution", 5500 + 1000 * t, pres);
        end
        {test_sel, tin} = 4'hF;
        #1;
        check("test inputs", 3'b111, {sg, s1g, s2g});
        test_sel = 1'b0;
        #1;
        check("normal inputs", 3'b000, {sg, s1g, s2g});
        $display("test trim and test inputs done");
        report_and_stop();
    end
endmodule : tdc_readout_reset_timer_flags_bench
